// [hdl/spi_access_pkg.sv]
// constants and types for the serial register access port
// Notes on behaviour
// - the host holds chip select low for a whole transaction and the data output floats while it is high.
// - the serial clock idles low, outputs change on its falling edge and inputs are sampled on its rising edge;
//   each byte after the first loads its msb just after the rising edge ending the byte before.
// - every transfer unit is one byte shifted most significant bit first in both directions.
// - the top bit of the first (command) byte selects single-register mode at 0 and burst mode at 1.
// - the next bit of the command byte selects read at 0 and write at 1.
// - the low six bits of the command byte are the register address.
// - while the command byte shifts in, the contents of register 0x00 shift out.
// - a single read returns the addressed register in the second byte and ignores the incoming byte.
// - a single write takes the new value from the second byte while the output sends 0x00.
// - in burst mode each further byte uses the next address, holding at 0x3f once reached.
// - a burst runs until chip select rises, after which the next low period is a new transaction.
// - address 0x3f is the fifo port, pushing to the transmit fifo or popping from the receive fifo.
// - after power-on and after leaving shutdown every register holds its default value.
package spi_access_pkg;
    localparam int          BYTE_W        = 8;
    localparam int          ADDR_W        = 6;
    localparam int          REG_COUNT     = 63;       // 0x00..0x3e
    localparam int          CMD_BURST_BIT = 7;
    localparam int          CMD_WRITE_BIT = 6;
    localparam logic [5:0]  STATUS_ADDR   = 6'h00;
    localparam logic [5:0]  FIFO_ADDR     = 6'h3f;
    localparam logic [7:0]  REG_RESET     = 8'h00;
    localparam logic [7:0]  WRITE_FILLER  = 8'h00;
    localparam logic [7:0]  EMPTY_READ    = 8'h00;
    localparam logic [2:0]  LAST_BIT      = 3'h7;
    localparam logic [2:0]  BIT_ZERO      = 3'h0;
    localparam logic [5:0]  ADDR_STEP     = 6'h01;
    localparam logic [1:0]  SYNC_ZERO     = 2'h0;
    localparam logic [1:0]  SYNC_ONE      = 2'h3;

    // transaction phase, gray along command -> data -> done
    typedef enum logic [1:0] {
        PH_CMD  = 2'b00,
        PH_DATA = 2'b01,
        PH_DONE = 2'b11
    } phase_type;
endpackage

// [hdl/spi_register_access_slave.sv]
// serial register access port with register file and fifo window
`timescale 1ns/100ps
module spi_register_access_slave #(
    parameter int DATA_W = spi_access_pkg::BYTE_W
) (
    input  wire logic                              ref_clk,
    input  wire logic                              rst_n,
    input  wire logic                              shutdown,
    input  wire logic                              sck,
    input  wire logic                              csn,
    input  wire logic                              mosi,
    output logic                                   miso_out,
    output logic                                   miso_oe_n,
    output logic                                   tx_valid,
    input  wire logic                              tx_ready,
    output logic [DATA_W-1:0]                      tx_data,
    input  wire logic                              rx_valid,
    output logic                                   rx_ready,
    input  wire logic [DATA_W-1:0]                 rx_data,
    output logic                                   wr_pulse,
    output logic [spi_access_pkg::ADDR_W-1:0]      wr_addr,
    output logic [DATA_W-1:0]                      wr_data,
    output logic                                   tx_drop
);
    import spi_access_pkg::*;

    logic                 reset_all;
    logic [1:0]           sck_sync_reg;
    logic [1:0]           csn_sync_reg;
    logic [1:0]           mosi_sync_reg;
    logic                 sck_prev_reg, csn_prev_reg;
    logic                 sck_rise, sck_fall, cs_fall, cs_high;
    logic [2:0]           bit_cnt_reg;
    logic [DATA_W-1:0]    in_sh_reg;
    logic [DATA_W-1:0]    in_byte;
    logic                 byte_done;
    phase_type            phase_reg;
    logic                 burst_reg, write_reg;
    logic [ADDR_W-1:0]    addr_reg;
    logic [DATA_W-1:0]    out_sh_reg;
    logic                 fresh_reg, load_pend_reg, load_zero_reg;
    logic [ADDR_W-1:0]    load_addr_reg;
    logic                 oe_n_reg, rx_ready_reg;
    logic [DATA_W-1:0]    mem_reg [REG_COUNT];
    logic                 wr_en, push_en, buf_ready;
    logic                 tx_valid_reg, skid_valid_reg;
    logic [DATA_W-1:0]    tx_data_reg;
    logic [DATA_W-1:0]    skid_data_reg;
    logic                 wr_pulse_reg, tx_drop_reg;
    logic [ADDR_W-1:0]    wr_addr_reg;
    logic [DATA_W-1:0]    wr_data_reg;
    logic [ADDR_W-1:0]    next_addr;
    logic                 next_zero;

    // shutdown exit reloads defaults just like power-on
    assign reset_all = !rst_n || shutdown;
    // two-stage synchronisers; csn resets to deselected
    always_ff @(posedge ref_clk)
    begin
        if (reset_all)
        begin
            sck_sync_reg  <= SYNC_ZERO;
            csn_sync_reg  <= SYNC_ONE;
            mosi_sync_reg <= SYNC_ZERO;
            sck_prev_reg  <= 1'b0;
            csn_prev_reg  <= 1'b1;
        end
        else
        begin
            sck_sync_reg  <= {sck_sync_reg[0], sck};
            csn_sync_reg  <= {csn_sync_reg[0], csn};
            mosi_sync_reg <= {mosi_sync_reg[0], mosi};
            sck_prev_reg  <= sck_sync_reg[1];
            csn_prev_reg  <= csn_sync_reg[1];
        end
    end

    // edges only count while selected
    assign cs_high   = csn_sync_reg[1];
    assign cs_fall   = csn_prev_reg && !cs_high;
    assign sck_rise  = !cs_high && sck_sync_reg[1] && !sck_prev_reg;
    assign sck_fall  = !cs_high && !sck_sync_reg[1] && sck_prev_reg;
    assign in_byte   = {in_sh_reg[DATA_W-2:0], mosi_sync_reg[1]};
    assign byte_done = sck_rise && (bit_cnt_reg == LAST_BIT);
    // input shifter and bit counter
    always_ff @(posedge ref_clk)
    begin
        if (reset_all || cs_high)
        begin
            bit_cnt_reg <= BIT_ZERO;
            in_sh_reg   <= REG_RESET;
        end
        else if (sck_rise)
        begin
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            in_sh_reg   <= in_byte;
        end
    end
    // address that the byte after this one will use
    always_comb
    begin
        next_addr = addr_reg;
        next_zero = 1'b1;
        if (phase_reg == PH_CMD)
        begin
            next_addr = in_byte[ADDR_W-1:0];
            next_zero = in_byte[CMD_WRITE_BIT];
        end
        else if (phase_reg == PH_DATA && burst_reg)
        begin
            next_zero = write_reg;
            if (addr_reg != FIFO_ADDR)
                next_addr = addr_reg + ADDR_STEP;
        end
    end

    // transaction phase; ends only on chip select high
    always_ff @(posedge ref_clk)
    begin
        if (reset_all || cs_high)
        begin
            phase_reg <= PH_CMD;
            burst_reg <= 1'b0;
            write_reg <= 1'b0;
            addr_reg  <= STATUS_ADDR;
        end
        else if (byte_done)
        begin
            addr_reg <= next_addr;
            unique case (phase_reg)
                PH_CMD:
                begin
                    burst_reg <= in_byte[CMD_BURST_BIT];
                    write_reg <= in_byte[CMD_WRITE_BIT];
                    phase_reg <= PH_DATA;
                end
                PH_DATA:
                    if (!burst_reg)
                        phase_reg <= PH_DONE;
                PH_DONE:
                    phase_reg <= PH_DONE;   // extra bytes are ignored
                default:
                    phase_reg <= PH_CMD;
            endcase
        end
    end
    // a write lands only on a completed data byte
    assign wr_en   = byte_done && phase_reg == PH_DATA && write_reg
                     && addr_reg != FIFO_ADDR;
    assign push_en = byte_done && phase_reg == PH_DATA && write_reg
                     && addr_reg == FIFO_ADDR;

    // register file, one process per entry
    generate
        for (genvar i = 0; i < REG_COUNT; i++)
        begin : g_reg
            always_ff @(posedge ref_clk)
            begin
                if (reset_all)
                    mem_reg[i] <= REG_RESET;
                else if (wr_en && addr_reg == ADDR_W'(i))
                    mem_reg[i] <= in_byte;
            end
        end
    endgenerate

    // write notification towards the rest of the chip
    always_ff @(posedge ref_clk)
    begin
        if (reset_all)
        begin
            wr_pulse_reg <= 1'b0;
            wr_addr_reg  <= STATUS_ADDR;
            wr_data_reg  <= REG_RESET;
            tx_drop_reg  <= 1'b0;
        end
        else
        begin
            wr_pulse_reg <= wr_en;
            tx_drop_reg  <= push_en && !buf_ready;  // host cannot be stalled
            if (wr_en)
            begin
                wr_addr_reg <= addr_reg;
                wr_data_reg <= in_byte;
            end
        end
    end

    // schedule the next output byte; fifo pops ride the load cycle
    always_ff @(posedge ref_clk)
    begin
        if (reset_all || cs_high)
        begin
            load_pend_reg <= 1'b0;
            load_zero_reg <= 1'b1;
            load_addr_reg <= STATUS_ADDR;
            rx_ready_reg  <= 1'b0;
        end
        else
        begin
            load_pend_reg <= byte_done;
            rx_ready_reg  <= byte_done && phase_reg != PH_DONE && !next_zero
                             && next_addr == FIFO_ADDR;
            if (byte_done)
            begin
                load_zero_reg <= next_zero || phase_reg != PH_CMD && !burst_reg;
                load_addr_reg <= next_addr;
            end
        end
    end

    // output shifter: first bit is set up before the first rising edge
    always_ff @(posedge ref_clk)
    begin
        if (reset_all)
        begin
            out_sh_reg <= REG_RESET;
            fresh_reg  <= 1'b0;
        end
        else if (cs_fall)
        begin
            out_sh_reg <= mem_reg[STATUS_ADDR];
            fresh_reg  <= 1'b0;
        end
        else if (load_pend_reg)
        begin
            fresh_reg <= 1'b1;
            if (load_zero_reg)
                out_sh_reg <= WRITE_FILLER;
            else if (load_addr_reg == FIFO_ADDR)
                out_sh_reg <= rx_valid ? rx_data : EMPTY_READ;
            else
                out_sh_reg <= mem_reg[load_addr_reg];
        end
        else if (sck_fall)
        begin
            // the fall after a byte's last bit shows the new msb as loaded
            fresh_reg <= 1'b0;
            if (!fresh_reg)
                out_sh_reg <= {out_sh_reg[DATA_W-2:0], 1'b0};
        end
    end

    // output enable follows the synchronised select
    always_ff @(posedge ref_clk)
    begin
        if (reset_all)
            oe_n_reg <= 1'b1;
        else
            oe_n_reg <= cs_high;
    end

    // two-entry skid buffer towards the transmit fifo
    // a stage that drains this cycle frees room, so no false drop
    assign buf_ready = !skid_valid_reg || tx_ready;
    always_ff @(posedge ref_clk)
    begin
        if (reset_all)
        begin
            tx_valid_reg   <= 1'b0;
            tx_data_reg    <= REG_RESET;
            skid_valid_reg <= 1'b0;
            skid_data_reg  <= REG_RESET;
        end
        else if (!tx_valid_reg || tx_ready)
        begin
            if (skid_valid_reg)
            begin
                tx_valid_reg   <= 1'b1;
                tx_data_reg    <= skid_data_reg;
                skid_valid_reg <= push_en;
                if (push_en)
                    skid_data_reg <= in_byte;
            end
            else
            begin
                tx_valid_reg <= push_en;
                if (push_en)
                    tx_data_reg <= in_byte;
            end
        end
        else if (push_en && buf_ready)
        begin
            skid_valid_reg <= 1'b1;
            skid_data_reg  <= in_byte;
        end
    end

    assign miso_out  = out_sh_reg[DATA_W-1];
    assign miso_oe_n = oe_n_reg;
    assign tx_valid  = tx_valid_reg;
    assign tx_data   = tx_data_reg;
    assign rx_ready  = rx_ready_reg;
    assign wr_pulse  = wr_pulse_reg;
    assign wr_addr   = wr_addr_reg;
    assign wr_data   = wr_data_reg;
    assign tx_drop   = tx_drop_reg;
endmodule // spi_register_access_slave

// [tb/spi_access_chk.sv]
// concurrent checks on the serial register access port
`timescale 1ns/100ps
module spi_access_chk
    import spi_access_pkg::*;
#(
    parameter int DATA_W = 8
) (
    input wire logic                              ref_clk,
    input wire logic                              rst_n,
    input wire logic                              shutdown,
    input wire logic                              csn,
    input wire logic                              miso_oe_n,
    input wire logic                              tx_valid,
    input wire logic                              tx_ready,
    input wire logic [DATA_W-1:0]                 tx_data,
    input wire logic                              rx_ready,
    input wire logic                              wr_pulse,
    input wire logic [spi_access_pkg::ADDR_W-1:0] wr_addr,
    input wire logic [DATA_W-1:0]                 wr_data,
    input wire logic                              tx_drop
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    // output enable follows chip select after the synchroniser delay
    property p_oe_idle; csn [*6] |-> miso_oe_n; endproperty
    a_oe_idle: assert property (p_oe_idle) else $error("miso driven");
    property p_oe_drive; !csn [*6] |-> !miso_oe_n; endproperty
    a_oe_drive: assert property (p_oe_drive) else $error("miso off");
    property p_wr_one; wr_pulse |=> !wr_pulse; endproperty
    a_wr_one: assert property (p_wr_one) else $error("long write");
    // the fifo window never reaches the register file
    property p_wr_fifo; wr_pulse |-> wr_addr != FIFO_ADDR; endproperty
    a_wr_fifo: assert property (p_wr_fifo) else $error("fifo write");
    // a write only completes while the host still selects the port
    property p_wr_sel; wr_pulse |-> !$past(csn, 4); endproperty
    a_wr_sel: assert property (p_wr_sel) else $error("late write");
    property p_wr_hold;
        disable iff (!rst_n || shutdown)
        !wr_pulse |-> $stable(wr_addr) && $stable(wr_data);
    endproperty
    a_wr_hold: assert property (p_wr_hold) else $error("write moved");
    property p_tx_hold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_data);
    endproperty
    a_tx_hold: assert property (p_tx_hold) else $error("tx lost");
    property p_drop; tx_drop |-> tx_valid ##1 !tx_drop; endproperty
    a_drop: assert property (p_drop) else $error("bad drop");
    property p_rx_one; rx_ready |=> !rx_ready; endproperty
    a_rx_one: assert property (p_rx_one) else $error("long pop");
    property p_shut; shutdown |=> miso_oe_n && !tx_valid && !wr_pulse;
    endproperty
    a_shut: assert property (p_shut) else $error("no defaults");
endmodule // spi_access_chk

bind spi_register_access_slave spi_access_chk #(.DATA_W(DATA_W)) chk_u (
    .ref_clk, .rst_n, .shutdown, .csn, .miso_oe_n, .tx_valid, .tx_ready,
    .tx_data, .rx_ready, .wr_pulse, .wr_addr, .wr_data, .tx_drop);

// [tb/spi_host_model.sv]
// host controller model driving the serial port pins
`timescale 1ns/100ps
module spi_host_model (
    input  wire logic ref_clk,
    output logic      sck,
    output logic      csn,
    output logic      mosi,
    input  wire logic miso_pin
);
    // idle: deselected, clock parked low
    initial
    begin
        sck  = 1'b0;
        csn  = 1'b1;
        mosi = 1'b0;
    end
    // select, then leave time for the first bit to appear
    task automatic open_x();
        @(posedge ref_clk);
        csn <= 1'b0;
        repeat (8) @(posedge ref_clk);
    endtask
    // msb first; four clocks a half period give the 200 ns sck period;
    // miso read late in the high phase since the port's synchroniser
    // puts about four clocks between sck and its output
    task automatic shift(input logic [7:0] dout, input int nbits,
                         output logic [7:0] din);
        din = 8'h00;
        for (int i = 7; i > 7 - nbits; i--)
        begin
            mosi <= dout[i];
            repeat (4) @(posedge ref_clk);
            sck <= 1'b1;
            repeat (4) @(posedge ref_clk);
            din[i] = miso_pin;
            sck <= 1'b0;
        end
    endtask
    // deselect ends any burst; keep the gap well above 3 clocks
    task automatic close_x();
        repeat (4) @(posedge ref_clk);
        csn  <= 1'b1;
        mosi <= ~mosi;
        repeat (12) @(posedge ref_clk);
    endtask
endmodule // spi_host_model

// [tb/tb_top.sv]
// self-checking bench for the serial register access port
`timescale 1ns/100ps
module tb_top;
    import spi_access_pkg::*;
    logic       ref_clk, rst_n, shutdown, sck, csn, mosi, miso_out;
    logic       miso_oe_n, tx_valid, tx_ready, rx_valid, rx_ready;
    logic       wr_pulse, tx_drop;
    logic [7:0] tx_data, rx_data, wr_data, rd;
    logic [5:0] wr_addr;
    wire        miso_pin;
    int         err_total = 0, samples_checked = 0;
    int         cyc = 0, drops = 0, wr_seen = 0;
    logic [7:0] txq[$], rxq[$];
    logic [7:0] v[3] = '{8'h11, 8'h22, 8'h33};

    assign miso_pin = miso_oe_n ? 1'bz : miso_out;
    spi_register_access_slave dut_u (.ref_clk, .rst_n, .shutdown, .sck,
        .csn, .mosi, .miso_out, .miso_oe_n, .tx_valid, .tx_ready, .tx_data,
        .rx_valid, .rx_ready, .rx_data, .wr_pulse, .wr_addr, .wr_data,
        .tx_drop);
    spi_host_model host_u (.ref_clk, .sck, .csn, .mosi, .miso_pin);

    initial
    begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    // fifo sides, write monitor and a run-time ceiling
    always @(posedge ref_clk)
    begin
        cyc <= cyc + 1;
        if (tx_valid && tx_ready) txq.push_back(tx_data);
        if (tx_drop) drops <= drops + 1;
        if (wr_pulse) wr_seen <= wr_seen + 1;
        if (rx_ready && rx_valid) void'(rxq.pop_front());
        rx_valid <= rxq.size() != 0;
        rx_data <= rxq.size() != 0 ? rxq[0] : 8'hff;
        if (cyc == 20000)
        begin
            err_total++;
            complete_run();
        end
    end
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rw(input logic [7:0] cmd, dat, e0, e1);
        logic [7:0] r0, r1;
        host_u.open_x();
        host_u.shift(cmd, 8, r0);
        host_u.shift(dat, 8, r1);
        host_u.close_x();
        check(r0, e0);
        check(r1, e1);
    endtask
    task automatic t_single();
        rw(8'h45, 8'h5a, REG_RESET, WRITE_FILLER);
        check({2'b00, wr_addr}, 8'h05);
        check(wr_data, 8'h5a);
        rw(8'h40, 8'ha5, REG_RESET, WRITE_FILLER);
        rw(8'h05, 8'h33, 8'ha5, 8'h5a);
        check(8'(wr_seen), 8'h02);
        $display("single transfers done");
    endtask
    task automatic t_burst();
        host_u.open_x();
        host_u.shift(8'hfc, 8, rd);
        for (int i = 0; i < 3; i++) host_u.shift(v[i], 8, rd);
        host_u.close_x();
        host_u.open_x();
        host_u.shift(8'hbc, 8, rd);
        check(rd, 8'ha5);
        for (int i = 0; i < 5; i++)
        begin
            host_u.shift(8'h00, 8, rd);
            check(rd, i < 3 ? v[i] : EMPTY_READ);
        end
        host_u.close_x();
        $display("burst transfers done");
    endtask
    task automatic t_fifo();
        @(posedge ref_clk) tx_ready <= 1'b0;
        rxq = '{8'h61, 8'h62, 8'h63, 8'h64};
        host_u.open_x();
        host_u.shift(8'hff, 8, rd);
        for (int i = 0; i < 3; i++) host_u.shift(v[i], 8, rd);
        host_u.close_x();
        check(8'(drops), 8'h01);
        @(posedge ref_clk) tx_ready <= 1'b1;
        for (int i = 0; i < 20 && txq.size() < 2; i++) @(posedge ref_clk);
        check(8'(txq.size()), 8'h02);
        for (int i = 0; i < 2; i++) check(txq[i], v[i]);
        host_u.open_x();
        host_u.shift(8'hbf, 8, rd);
        for (int i = 0; i < 2; i++)
        begin
            host_u.shift(8'h00, 8, rd);
            check(rd, 8'h61 + 8'(i));
        end
        host_u.close_x();
        // the burst pops one byte ahead, so 0x63 leaves unseen at deselect
        rw(8'h3f, 8'h00, 8'ha5, 8'h64);
        rw(8'h3f, 8'h00, 8'ha5, EMPTY_READ);
        check(8'(rxq.size()), 8'h00);
        $display("fifo window done");
    endtask
    task automatic t_partial();
        int seen;
        seen = wr_seen;
        host_u.open_x();
        host_u.shift(8'h45, 8, rd);
        host_u.shift(8'h77, 5, rd);
        host_u.close_x();
        check(8'(wr_seen - seen), 8'h00);
        rw(8'h05, 8'h00, 8'ha5, 8'h5a);
        $display("cut byte done");
    endtask
    task automatic t_shutdown();
        @(posedge ref_clk) shutdown <= 1'b1;
        repeat (2) @(posedge ref_clk);
        shutdown <= 1'b0;
        rw(8'h05, 8'h00, REG_RESET, REG_RESET);
        $display("shutdown wake done");
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // reset for four clocks, then the scenarios in turn
    initial
    begin
        rst_n = 1'b0;
        shutdown = 1'b0;
        tx_ready = 1'b1;
        repeat (4) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_single();
        t_burst();
        t_fifo();
        t_partial();
        t_shutdown();
        complete_run();
    end
endmodule // tb_top
